// [ssp_top.sv]
// Synchronous slave serial port with an AXI4-Lite register slave.
// Assumes the far master drives shift_clock_pin slower than aclk/6 and that
// the data pin is resolved from data_oe by the surrounding wire model.
// No power states exist here: shifting depends only on the pin clock.
`timescale 1ns/1ps
module ssp_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Serial link
    input wire logic shift_clock_pin,
    input wire logic data_i,
    output logic data_o,
    output logic data_oe,
    // Wake and interrupt
    output logic wake_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic awv;
        logic [ADDR_W-1:0] awa;
        logic wv;
        logic [7:0] wd;
        logic ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [7:0] rd;
        logic [1:0] rr;
        logic [7:0] intctl;
        logic [7:0] ien;
        logic [7:0] ipri;
        logic serial_port_enable;
        logic rx9;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic adden;
        logic overrun_error;
        logic received_ninth_bit;
        logic clock_source_select;
        logic tx9;
        logic transmit_enable;
        logic sync;
        logic sendb;
        logic brgh;
        logic transmit_ninth_bit;
        logic [7:0] baud;
        logic [7:0] divh;
        logic [7:0] divl;
        logic [7:0] txbuf;
        logic txfull;
        logic [8:0] transmit_shift_register;
        logic tbusy;
        logic [3:0] tcnt;
        logic [8:0] receive_shift_register;
        logic [3:0] rcnt;
        logic [7:0] rcbuf;
        logic receive_buffer_full_flag;
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic dt_s1;
        logic dt_s2;
    } ssp_state_s;

    ssp_state_s q;
    ssp_state_s d;

    // Address decode shared by the read and write paths
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        mapped = (o[1:0] == 2'h0) && (o <= ssp_pkg::OFF_RXBUF);
    endfunction

    // Last bit index of a word, 8 or 9 bits
    function automatic logic [3:0] last_bit(input logic nine);
        last_bit = nine ? ssp_pkg::LAST9 : ssp_pkg::LAST8;
    endfunction

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic active;
    logic ck_now;
    logic ck_old;
    logic fall;
    logic transmit_buffer_empty_flag;
    logic [7:0] rx_stat;
    logic [7:0] tx_stat;
    logic [7:0] flags;
    logic [7:0] rdval;
    logic [7:0] ra;

    // Slave runs only when enabled and clock source is external
    assign active = q.serial_port_enable & ~q.clock_source_select;
    // Polarity applies to the sampled pin for both directions
    assign ck_now = q.ck_s2 ^ q.baud[ssp_pkg::B_POLINV];
    assign ck_old = q.ck_s3 ^ q.baud[ssp_pkg::B_POLINV];
    // Falling edge of the external clock, the only timing the port uses
    assign fall = ck_old & ~ck_now & active;
    // Empty flag is derived from buffer state, so software cannot clear it
    assign transmit_buffer_empty_flag = ~q.txfull;
    assign rx_stat = {q.serial_port_enable, q.rx9, q.single_receive_enable, q.continuous_receive_enable, q.adden, 1'b0, q.overrun_error, q.received_ninth_bit};
    // Shift register empty bit is status only, no interrupt tie
    assign tx_stat = {q.clock_source_select, q.tx9, q.transmit_enable, q.sync, q.sendb, q.brgh, ~q.tbusy, q.transmit_ninth_bit};
    assign flags = {2'h0, q.receive_buffer_full_flag, transmit_buffer_empty_flag, 4'h0};
    assign ra = 8'(s_axi_araddr);

    // Read mux
    always_comb
    begin
        case (ra)
            ssp_pkg::OFF_INTCTL: rdval = q.intctl;
            ssp_pkg::OFF_FLAGS: rdval = flags;
            ssp_pkg::OFF_IEN: rdval = q.ien;
            ssp_pkg::OFF_IPRI: rdval = q.ipri;
            ssp_pkg::OFF_RXSTAT: rdval = rx_stat;
            ssp_pkg::OFF_TXBUF: rdval = q.txbuf;
            ssp_pkg::OFF_TXSTAT: rdval = tx_stat;
            ssp_pkg::OFF_BAUDCTL: rdval = q.baud;
            ssp_pkg::OFF_DIVH: rdval = q.divh;
            ssp_pkg::OFF_DIVL: rdval = q.divl;
            ssp_pkg::OFF_RXBUF: rdval = q.rcbuf;
            default: rdval = ssp_pkg::RST_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Order matters: software clears come before hardware sets, so a set
    // in the same cycle wins.
    always_comb
    begin
        logic [8:0] rw;
        logic [7:0] wo;
        rw = q.receive_shift_register;
        wo = 8'(q.awa);
        d = q;
        // Two-flop synchronisers; third stage only feeds the edge detector
        d.ck_s1 = shift_clock_pin;
        d.ck_s2 = q.ck_s1;
        d.ck_s3 = q.ck_s2;
        d.dt_s1 = data_i;
        d.dt_s2 = q.dt_s1;

        // Read channel; reading the receive buffer frees it
        if (s_axi_arvalid && !q.rv)
        begin
            d.rv = 1'b1;
            d.rd = rdval;
            d.rr = mapped(s_axi_araddr) ? ssp_pkg::RESP_OK : ssp_pkg::RESP_ERR;
            // A word finishing in this same cycle is judged on the old flag below, so a full buffer still latches an overrun
            if (ra == ssp_pkg::OFF_RXBUF)
            begin
                d.receive_buffer_full_flag = 1'b0;
            end
        end
        else if (q.rv && s_axi_rready)
        begin
            d.rv = 1'b0;
        end

        // Transmit: load from buffer when shift register is idle
        // Loading frees the buffer, which is what raises the empty flag
        if (!q.tbusy && q.txfull && q.transmit_enable && active)
        begin
            d.transmit_shift_register = {q.transmit_ninth_bit, q.txbuf};
            d.tbusy = 1'b1;
            d.tcnt = 4'h0;
            d.txfull = 1'b0;
        end
        else if (q.tbusy && fall)
        begin
            // Buffered word stays put until this word is done
            d.transmit_shift_register = {1'b0, q.transmit_shift_register[8:1]};
            d.tcnt = q.tcnt + 4'h1;
            if (q.tcnt == last_bit(q.tx9))
            begin
                d.tbusy = 1'b0;
            end
        end

        // Write address and data are taken independently
        if (s_axi_awvalid && !q.awv && !q.bv)
        begin
            d.awv = 1'b1;
            d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wv && !q.bv)
        begin
            d.wv = 1'b1;
            d.wd = s_axi_wdata[7:0];
            d.ws = s_axi_wstrb[0];
        end
        if (q.bv && s_axi_bready)
        begin
            d.bv = 1'b0;
        end

        // Register write once both halves are held
        if (q.awv && q.wv && !q.bv)
        begin
            d.awv = 1'b0;
            d.wv = 1'b0;
            d.bv = 1'b1;
            d.br = mapped(q.awa) ? ssp_pkg::RESP_OK : ssp_pkg::RESP_ERR;
            if (q.ws)
            begin
                case (wo)
                    ssp_pkg::OFF_INTCTL: d.intctl = q.wd;
                    ssp_pkg::OFF_IEN: d.ien = {1'b0, q.wd[6:0]};
                    ssp_pkg::OFF_IPRI: d.ipri = {1'b0, q.wd[6:0]};
                    ssp_pkg::OFF_RXSTAT:
                    begin
                        {d.serial_port_enable, d.rx9, d.single_receive_enable, d.continuous_receive_enable, d.adden} = q.wd[7:3];
                        // Clearing continuous receive is the only way software
                        // recovers from an overrun, so it also restarts the word
                        if (!q.wd[4])
                        begin
                            d.overrun_error = 1'b0;
                            d.rcnt = 4'h0;
                        end
                    end
                    // Buffer write is the only thing that clears the empty flag
                    ssp_pkg::OFF_TXBUF:
                    begin
                        d.txbuf = q.wd;
                        d.txfull = 1'b1;
                    end
                    ssp_pkg::OFF_TXSTAT:
                    begin
                        {d.clock_source_select, d.tx9, d.transmit_enable, d.sync, d.sendb, d.brgh} = q.wd[7:2];
                        d.transmit_ninth_bit = q.wd[0];
                    end
                    ssp_pkg::OFF_BAUDCTL:
                    begin
                        d.baud = q.wd;
                        d.baud[ssp_pkg::B_BAUD_GAP] = 1'b0;
                    end
                    ssp_pkg::OFF_DIVH: d.divh = q.wd;
                    ssp_pkg::OFF_DIVL: d.divl = q.wd;
                    default: d.rcnt = d.rcnt;
                endcase
            end
        end

        // Receive: sample on each falling edge while continuous receive is set and no overrun is latched.
        // No clock gating here, so this runs in any low-power state.
        if (q.continuous_receive_enable && !q.overrun_error && fall)
        begin
            rw[q.rcnt] = q.dt_s2;
            d.receive_shift_register = rw;
            d.rcnt = q.rcnt + 4'h1;
            if (q.rcnt == last_bit(q.rx9))
            begin
                d.rcnt = 4'h0;
                if (q.receive_buffer_full_flag)
                begin
                    // Unread word: drop the new one and latch the error
                    d.overrun_error = 1'b1;
                end
                else
                begin
                    d.rcbuf = rw[7:0];
                    // An 8-bit word reports a clear ninth bit rather than a
                    // bit left in the shift register by an earlier 9-bit word
                    d.received_ninth_bit = q.rx9 & rw[8];
                    d.receive_buffer_full_flag = 1'b1;
                end
            end
        end
        // Dropping continuous receive abandons any half-taken word
        else if (!q.continuous_receive_enable)
        begin
            d.rcnt = 4'h0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset: every field, synchronisers included, starts at zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus handshake outputs come straight from the held-request bits
    assign s_axi_awready = ~q.awv & ~q.bv;
    assign s_axi_wready = ~q.wv & ~q.bv;
    assign s_axi_bvalid = q.bv;
    assign s_axi_bresp = q.br;
    assign s_axi_arready = ~q.rv;
    assign s_axi_rvalid = q.rv;
    assign s_axi_rdata = {24'h000000, q.rd};
    assign s_axi_rresp = q.rr;
    // Drive the data pin only while a word is shifting
    assign data_o = q.transmit_shift_register[0];
    // Clearing transmit enable mid-word releases the pin; the word still counts out
    assign data_oe = q.tbusy & q.transmit_enable & active;
    // Wake needs only the local enable; the interrupt also needs both globals
    assign wake_o = (transmit_buffer_empty_flag & q.ien[ssp_pkg::B_TRANSMIT_BUFFER_EMPTY_FLAG]) | (q.receive_buffer_full_flag & q.ien[ssp_pkg::B_RECEIVE_BUFFER_FULL_FLAG]);
    assign irq_o = wake_o & q.intctl[ssp_pkg::B_GIE] & q.intctl[ssp_pkg::B_PERIPHERAL_INTERRUPT_ENABLE];
endmodule // ssp_top

// [ssp_pkg.sv]
// Constants for the synchronous slave serial port: offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite master and an external master driving the clock.
//
// Contract
// - Slave operation whenever the port is enabled and clock source select in transmit status is clear.
// - External master drives the shift clock; the device only follows it.
// - Shifting continues in any low-power mode, no clock gating.
// - First buffered word moves straight into the shift register and shifts out.
// - Second word waits in the buffer; transmit empty flag stays clear.
// - After the first word ends, second word loads, then empty flag sets.
// - Empty flag with transmit enable set raises wake; vectoring needs global enable.
// - Polarity invert bit inverts the shift clock pin for both directions.
// - Nine-bit transmit sends the ninth bit; shifting needs transmit enable and data.
// - Single receive enable is stored but has no effect.
// - Continuous receive set before low power still receives a whole word.
// - A finished word goes to the receive buffer and sets the full flag.
// - Full flag with receive enable raises wake; vectoring needs global enable.
// - Reading the receive buffer returns the 8-bit received word.
// - Clearing continuous receive clears latched receive errors.
// - Interrupt output also needs global and peripheral enables, bits 7 and 6.
// - Reception starts when continuous receive sets; nine-bit receive picks 9 bits.
// - Transmit empty flag cannot be cleared by software, only by a buffer write.
// - Shift register empty is read-only, set while idle, no interrupt.
// - Continuous receive keeps taking words until it is cleared or an overrun latches.
package ssp_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_INTCTL = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_IEN = 8'h08;
    localparam logic [7:0] OFF_IPRI = 8'h0c;
    localparam logic [7:0] OFF_RXSTAT = 8'h10;
    localparam logic [7:0] OFF_TXBUF = 8'h14;
    localparam logic [7:0] OFF_TXSTAT = 8'h18;
    localparam logic [7:0] OFF_BAUDCTL = 8'h1c;
    localparam logic [7:0] OFF_DIVH = 8'h20;
    localparam logic [7:0] OFF_DIVL = 8'h24;
    localparam logic [7:0] OFF_RXBUF = 8'h28;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_GIE = 7;
    localparam int B_PERIPHERAL_INTERRUPT_ENABLE = 6;
    localparam int B_RECEIVE_BUFFER_FULL_FLAG = 5;
    localparam int B_TRANSMIT_BUFFER_EMPTY_FLAG = 4;
    localparam int B_POLINV = 4;
    localparam int B_BAUD_GAP = 2;
    // ------------------------------------------------------------
    // Reset values, counts, responses
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] LAST8 = 4'h7;
    localparam logic [3:0] LAST9 = 4'h8;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// [ssp_checker.sv]
// Checker for the serial port: register bus handshakes and interrupt output.
// Sees only ssp_top ports; bound below.
`timescale 1ns/1ps
module ssp_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Interrupt
    input wire logic wake_o,
    input wire logic irq_o
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Responses hold until taken
    // ----------------------------------------
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response moved");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    // One cycle from read address to data; a new request needs a fresh handshake
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read data repeated");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && (!s_axi_rvalid || !s_axi_arready);
    endproperty
    a_busy: assert property (p_busy) else $error("request taken while busy");
    // Registers are one byte wide
    property p_rd_width;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("upper read bits set");
    property p_irq;
        $rose(irq_o) |-> wake_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without wake");
endmodule // ssp_checker

bind ssp_top ssp_checker u_ssp_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .wake_o(wake_o), .irq_o(irq_o)
);

// [ssp_link_master.sv]
// Model of the external master that clocks the serial port.
// Assumes frames are started by the bench; the clock stands still between them.
`timescale 1ns/1ps
module ssp_link_master (
    // Link pins
    output logic shift_clock_pin,
    output logic data_i,
    input wire logic data_o,
    input wire logic data_oe,
    // Polarity the port expects
    input wire logic inv
);
    logic clk_raw = 1'h1;
    // Idle level follows the polarity so the port sees no edge between frames
    assign shift_clock_pin = clk_raw ^ inv;
    initial data_i = 1'h0;
    // LSB first: drive on the rise, sample the port just before the fall
    task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
        rx = 9'h000;
        #1.3;
        for (int i = 0; i < n; i++)
        begin
            data_i = tx[i];
            #62.5;
            rx[i] = data_o & data_oe;
            clk_raw = 1'h0;
            #62.5;
            clk_raw = 1'h1;
        end
        // Released line shows the inverse of its last bit
        data_i = ~tx[n-1];
    endtask
endmodule // ssp_link_master

// [tb_sync_slave_serial_port.sv]
// Bench for the serial port: register tasks over AXI4-Lite, link frames via the model.
// Assumes ssp_pkg, ssp_top, the checker and ssp_link_master are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected at %0t: %h", $time, g); end end
module tb_sync_slave_serial_port;
    // Drive, outputs and counters
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, inv = 1'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00, wd = 8'h00;
    logic awr, wrdy, bv, arr, rv, dout, doe, sck, din, wake, irq;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rd;
    logic [7:0] cfg_rx [3] = '{8'h30, 8'ha0, 8'h90};
    logic [7:0] cfg_tx [3] = '{8'h30, 8'h30, 8'hb0};
    int n_errors = 0;
    int checks = 0;
    // 250 MHz clock
    always #2 aclk = ~aclk;
    ssp_top #(
        .ADDR_W(8)
    ) u_ssp_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata({24'h000000, wd}), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .shift_clock_pin(sck), .data_i(din),
        .data_o(dout), .data_oe(doe), .wake_o(wake), .irq_o(irq)
    );
    ssp_link_master u_ssp_link_master (
        .shift_clock_pin(sck), .data_i(din), .data_o(dout), .data_oe(doe), .inv(inv)
    );
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awv && awr) awv <= 1'h0;
            if (wv && wrdy) wv <= 1'h0;
        end
        while (!bv && n < 99);
        br <= 1'h0;
        last_resp = bresp;
        if (n >= 99)
        begin
            n_errors++;
            $display("unexpected at %0t: no write response", $time);
        end
    endtask
    // Read and compare the low byte
    task automatic ck(input logic [7:0] a, input logic [7:0] e);
        int n = 0;
        @(posedge aclk);
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arv && arr) arv <= 1'h0;
        end
        while (!rv && n < 99);
        rr <= 1'h0;
        last_resp = rresp;
        if (n >= 99)
        begin
            n_errors++;
            $display("unexpected at %0t: no read data", $time);
        end
        `CHK(rd[7:0], e)
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog, well beyond the expected run
    initial
    begin
        #100000;
        n_errors++;
        close_out();
    end
    // Test sequence
    initial
    begin
        logic [8:0] got;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        ck(ssp_pkg::OFF_TXSTAT, 8'h02);
        wr(ssp_pkg::OFF_FLAGS, 8'h00);
        `CHK(last_resp, ssp_pkg::RESP_OK)
        ck(ssp_pkg::OFF_FLAGS, 8'h10);
        wr(8'h2c, 8'h55);
        `CHK(last_resp, ssp_pkg::RESP_ERR)
        ck(8'h2c, 8'h00);
        `CHK(last_resp, ssp_pkg::RESP_ERR)
        $display("registers done");
        wr(ssp_pkg::OFF_RXSTAT, 8'h80);
        wr(ssp_pkg::OFF_TXSTAT, 8'h30);
        wr(ssp_pkg::OFF_IEN, 8'h10);
        `CHK(wake, 1'h1)
        `CHK(irq, 1'h0)
        wr(ssp_pkg::OFF_INTCTL, 8'hc0);
        wr(ssp_pkg::OFF_TXBUF, 8'ha5);
        wr(ssp_pkg::OFF_TXBUF, 8'h3c);
        ck(ssp_pkg::OFF_FLAGS, 8'h00);
        `CHK(irq, 1'h0)
        u_ssp_link_master.xfer(8, 9'h000, got);
        `CHK(got[7:0], 8'ha5)
        ck(ssp_pkg::OFF_FLAGS, 8'h10);
        `CHK(irq, 1'h1)
        u_ssp_link_master.xfer(8, 9'h000, got);
        `CHK(got[7:0], 8'h3c)
        ck(ssp_pkg::OFF_TXSTAT, 8'h32);
        $display("transmit done");
        // Polarity changes only while the port is off, so no stray edge counts
        wr(ssp_pkg::OFF_RXSTAT, 8'h00);
        inv <= 1'h1;
        wr(ssp_pkg::OFF_BAUDCTL, 8'h10);
        wr(ssp_pkg::OFF_IEN, 8'h20);
        wr(ssp_pkg::OFF_TXSTAT, 8'h51);
        wr(ssp_pkg::OFF_RXSTAT, 8'hd0);
        wr(ssp_pkg::OFF_TXBUF, 8'hc3);
        `CHK(doe, 1'h0)
        wr(ssp_pkg::OFF_TXSTAT, 8'h71);
        ck(ssp_pkg::OFF_FLAGS, 8'h10);
        `CHK(doe, 1'h1)
        u_ssp_link_master.xfer(9, 9'h15a, got);
        `CHK(got, 9'h1c3)
        `CHK(wake, 1'h1)
        `CHK(irq, 1'h1)
        ck(ssp_pkg::OFF_FLAGS, 8'h30);
        ck(ssp_pkg::OFF_RXSTAT, 8'hd1);
        ck(ssp_pkg::OFF_RXBUF, 8'h5a);
        $display("nine bit done");
        wr(ssp_pkg::OFF_RXSTAT, 8'h00);
        inv <= 1'h0;
        wr(ssp_pkg::OFF_BAUDCTL, 8'h00);
        wr(ssp_pkg::OFF_RXSTAT, 8'h90);
        u_ssp_link_master.xfer(8, 9'h066, got);
        u_ssp_link_master.xfer(8, 9'h099, got);
        ck(ssp_pkg::OFF_RXSTAT, 8'h92);
        wr(ssp_pkg::OFF_RXSTAT, 8'h80);
        ck(ssp_pkg::OFF_RXSTAT, 8'h80);
        ck(ssp_pkg::OFF_RXBUF, 8'h66);
        $display("overrun done");
        // Port off, single receive only, clock source set: nothing is received
        for (int i = 0; i < 3; i++)
        begin
            wr(ssp_pkg::OFF_TXSTAT, cfg_tx[i]);
            wr(ssp_pkg::OFF_RXSTAT, cfg_rx[i]);
            u_ssp_link_master.xfer(8, 9'h0ff, got);
            ck(ssp_pkg::OFF_FLAGS, 8'h10);
        end
        $display("disabled done");
        close_out();
    end
endmodule // tb_sync_slave_serial_port
